// file: verilog/ssmc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the supervisor mode control
// Assumes: 200 MHz system clock
// Notes: Included by every design file that needs a number
`ifndef SSMC_DEFS_SVH
`define SSMC_DEFS_SVH

`define SSMC_CLK_NS 5
`define SSMC_FP_DLY_NS 2000
`define SSMC_NORM_DLY_NS 150000
`define SSMC_WIN_NS 1000
`define SSMC_FP_DLY_CYC ((`SSMC_FP_DLY_NS + `SSMC_CLK_NS - 1) / `SSMC_CLK_NS)
`define SSMC_NORM_DLY_CYC ((`SSMC_NORM_DLY_NS + `SSMC_CLK_NS - 1) / `SSMC_CLK_NS)
`define SSMC_WIN_CYC (`SSMC_WIN_NS / `SSMC_CLK_NS)

`define SSMC_OFF_LOW_CTL 32'h0000_0000
`define SSMC_OFF_HIGH_CTL 32'h0000_0004
`define SSMC_OFF_FLAGS 32'h0000_0008
`define SSMC_OFF_MASK 32'h0000_000c
`define SSMC_OFF_STATUS 32'h0000_0010
`define SSMC_OFF_COUNT 32'h0000_0014

`define SSMC_EV_LO_DONE 0
`define SSMC_EV_HI_DONE 1
`define SSMC_EV_RESET 2
`define SSMC_EV_HANG 3
`define SSMC_FLG_PEND_LO 8
`define SSMC_FLG_PEND_HI 9
`define SSMC_STS_WFAST 8
`define SSMC_STS_HAZ 9
`define SSMC_STS_HANG 10
`define SSMC_STS_DEEP 11
`define SSMC_CNT_RESET 8

`define SSMC_CTL_RST 6'h11
`define SSMC_MASK_RST 4'h0
`define SSMC_HSIZE_WORD 3'h2

`endif

// file: verilog/ssmc_pkg.sv
// Purpose: Types of the supervisor mode control
// Assumes: Constants live in ssmc_defs.svh
// Notes: Control layout bit 0 is the supervisor enable
package ssmc_pkg;

  typedef enum logic [1:0] {
    SSMC_OFF = 2'b00,
    SSMC_NORMAL = 2'b01,
    SSMC_FULL = 2'b10
  } ssmc_mode_e;

  typedef enum logic [1:0] {
    SSMC_AWAKE = 2'b00,
    SSMC_ENTRY = 2'b01,
    SSMC_ASLEEP = 2'b10,
    SSMC_HUNG = 2'b11
  } ssmc_wake_e;

  typedef struct packed {
    logic mon_fp;
    logic mon_en;
    logic auto_ctl;
    logic fp;
    logic keep;
    logic en;
  } ssmc_ctl_s;

  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
  } ssmc_tmr_s;

  typedef struct packed {
    logic a_wr;
    logic a_word;
    logic [31:0] a_addr;
    ssmc_ctl_s lo;
    ssmc_ctl_s hi;
    logic [3:0] evt;
    logic [3:0] msk;
    ssmc_wake_e mode;
    logic [7:0] win;
    logic haz;
    logic raise;
    logic [7:0] wake_cnt;
    logic [7:0] rst_cnt;
    logic [31:0] rdata;
    logic rdy;
    logic [7:0] st;
    logic wfast;
    logic irq;
    logic wake;
    logic rst;
    logic hang;
  } ssmc_top_s;

endpackage : ssmc_pkg

// file: verilog/ssmc_mode_map.sv
// Purpose: Active and deep-sleep mode of one supervisor or monitor
// Assumes: Monitors are fed with keep tied high
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module ssmc_mode_map (
  input wire logic en,
  input wire logic keep,
  input wire logic fp,
  input wire logic auto_ctl,
  output ssmc_pkg::ssmc_mode_e act_mode,
  output ssmc_pkg::ssmc_mode_e slp_mode,
  output logic wake_fast
);

  always_comb begin
    act_mode = ssmc_pkg::SSMC_OFF;
    slp_mode = ssmc_pkg::SSMC_OFF;
    wake_fast = ~en | fp;
    if (en) begin
      act_mode = fp ? ssmc_pkg::SSMC_FULL : ssmc_pkg::SSMC_NORMAL;
      if (keep && !auto_ctl) begin
        slp_mode = act_mode;
      end else if (keep && fp) begin
        slp_mode = ssmc_pkg::SSMC_NORMAL;
      end
    end
  end

endmodule : ssmc_mode_map

`default_nettype wire

// file: verilog/ssmc_settle_timer.sv
// Purpose: Comparator settling delay after a control write or a core level raise
// Assumes: SLOW_CYC at most 65536
// Notes: A start while running reloads the count
`timescale 1ns/1ps
`default_nettype none
`include "ssmc_defs.svh"

module ssmc_settle_timer #(
  parameter int unsigned SLOW_CYC = `SSMC_NORM_DLY_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic fast,
  output logic pending,
  output logic done
);

  localparam logic [15:0] FAST_LD = 16'(`SSMC_FP_DLY_CYC - 1);
  localparam logic [15:0] SLOW_LD = 16'(SLOW_CYC - 1);

  ssmc_pkg::ssmc_tmr_s tmr_q;
  ssmc_pkg::ssmc_tmr_s tmr_d;

  always_comb begin
    tmr_d = tmr_q;
    if (start) begin
      tmr_d.busy = 1'b1;
      tmr_d.cnt = fast ? FAST_LD : SLOW_LD;
    end else if (tmr_q.busy) begin
      if (tmr_q.cnt == 16'h0000) begin
        tmr_d.busy = 1'b0;
      end else begin
        tmr_d.cnt = tmr_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

  // Visible in the write cycle itself so a read behind it sees it
  assign pending = tmr_q.busy | start;
  assign done = tmr_q.busy & (tmr_q.cnt == 16'h0000) & ~start;

endmodule : ssmc_settle_timer

`default_nettype wire

// file: verilog/ssmc_top.sv
// Purpose: Mode control of the core and supply supervisors and monitors, AHB-Lite registers
// Assumes: One clock, single word transfers, all pins synchronous to CLK
// Notes: Zero wait states; modes follow the control registers one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "ssmc_defs.svh"

// Contract
// - Low side in full performance: settling delay of about 2 us.
// - Low side in normal mode: settling delay of about 150 us.
// - Request reset when settling delay ends before raised core level settles.
// - Interrupt within 1 us of hazardous deep entry leaves device hung.
// - Power-up clear or reset ends the hung state.
// - Hazard: low side fast wakeup or off, high side normal to off.
// - Low supervisor: off when disabled, else per full-perf, off in sleep.
// - Low supervisor with keep set: kept manually, reduced automatically.
// - Low monitor: off when disabled, kept manually, reduced automatically.
// - High supervisor and monitor follow the same scheme, own bits.
module ssmc_top #(
  parameter int unsigned NORM_DLY_CYC = `SSMC_NORM_DLY_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic LPM_DEEP,
  input wire logic WAKE_IRQ,
  input wire logic CORE_RAISE,
  input wire logic CORE_SETTLED,
  input wire logic POWER_UP_CLEAR,
  output logic [1:0] LOW_SUP_STATE,
  output logic [1:0] LOW_MON_STATE,
  output logic [1:0] HIGH_SUP_STATE,
  output logic [1:0] HIGH_MON_STATE,
  output logic WAKE_FAST,
  output logic WAKE_OUT,
  output logic HANG,
  output logic RESET_REQ,
  output logic IRQ
);

  localparam logic [7:0] WIN_LD = 8'(`SSMC_WIN_CYC - 1);

  localparam ssmc_pkg::ssmc_top_s STATE_RST = '{
    lo: `SSMC_CTL_RST,
    hi: `SSMC_CTL_RST,
    msk: `SSMC_MASK_RST,
    mode: ssmc_pkg::SSMC_AWAKE,
    rdy: 1'b1,
    default: '0
  };

  ssmc_pkg::ssmc_top_s state_q;
  ssmc_pkg::ssmc_top_s state_d;

  ssmc_pkg::ssmc_ctl_s wctl;
  ssmc_pkg::ssmc_mode_e act_m [4];
  ssmc_pkg::ssmc_mode_e slp_m [4];
  logic [3:0] fast_w;
  logic [5:0] wsel;
  logic [5:0] rsel;
  logic acc;
  logic wr_lo;
  logic wr_hi;
  logic lo_start;
  logic hi_start;
  logic lo_fast;
  logic hi_fast;
  logic [1:0] pend;
  logic lo_done;
  logic hi_done;
  logic lo_quick;
  logic hi_drop;
  logic haz_cfg;

  // One-hot register select for an address
  function automatic logic [5:0] reg_dec(input logic [31:0] a);
    reg_dec = 6'h00;
    case (a)
      `SSMC_OFF_LOW_CTL: reg_dec = 6'h01;
      `SSMC_OFF_HIGH_CTL: reg_dec = 6'h02;
      `SSMC_OFF_FLAGS: reg_dec = 6'h04;
      `SSMC_OFF_MASK: reg_dec = 6'h08;
      `SSMC_OFF_STATUS: reg_dec = 6'h10;
      `SSMC_OFF_COUNT: reg_dec = 6'h20;
      default: reg_dec = 6'h00;
    endcase
  endfunction : reg_dec

  // Bus address and data phase decode
  assign acc = HSEL & HREADY & HTRANS[1];
  assign wsel = (state_q.a_wr & state_q.a_word) ? reg_dec(state_q.a_addr) : 6'h00;
  assign rsel = reg_dec(HADDR);
  assign wctl = ssmc_pkg::ssmc_ctl_s'(HWDATA[5:0]);
  assign wr_lo = wsel[0];
  assign wr_hi = wsel[1];

  // Settling delays: control writes and core level raises
  assign lo_start = wr_lo | CORE_RAISE;
  assign hi_start = wr_hi;
  assign lo_fast = wr_lo ? wctl.fp : state_q.lo.fp;
  assign hi_fast = wr_hi ? wctl.fp : state_q.hi.fp;

  ssmc_settle_timer #(
    .SLOW_CYC(NORM_DLY_CYC)
  ) u_lo_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(lo_start),
    .fast(lo_fast),
    .pending(pend[0]),
    .done(lo_done)
  );

  ssmc_settle_timer #(
    .SLOW_CYC(NORM_DLY_CYC)
  ) u_hi_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(hi_start),
    .fast(hi_fast),
    .pending(pend[1]),
    .done(hi_done)
  );

  // Units 0..3: low supervisor, low monitor, high supervisor, high monitor
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_unit
      ssmc_pkg::ssmc_ctl_s c;
      assign c = (gi < 2) ? state_q.lo : state_q.hi;
      ssmc_mode_map u_map (
        .en((gi % 2 == 0) ? c.en : c.mon_en),
        .keep((gi % 2 == 0) ? c.keep : 1'b1),
        .fp((gi % 2 == 0) ? c.fp : c.mon_fp),
        .auto_ctl(c.auto_ctl),
        .act_mode(act_m[gi]),
        .slp_mode(slp_m[gi]),
        .wake_fast(fast_w[gi])
      );
    end
  endgenerate

  // Hazardous setup for deep entry
  assign lo_quick = fast_w[0] | fast_w[1];
  assign hi_drop = ((act_m[2] == ssmc_pkg::SSMC_NORMAL) && (slp_m[2] == ssmc_pkg::SSMC_OFF)) ||
                   ((act_m[3] == ssmc_pkg::SSMC_NORMAL) && (slp_m[3] == ssmc_pkg::SSMC_OFF));
  // Entering with a delay still pending is equally unsafe
  assign haz_cfg = (lo_quick & hi_drop) | (|pend);

  always_comb begin
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    logic deep;
    logic [31:0] rd;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    deep = 1'b0;
    rd = 32'h0000_0000;
    state_d = state_q;
    state_d.a_wr = acc & HWRITE;
    state_d.a_word = (HSIZE == `SSMC_HSIZE_WORD);
    state_d.a_addr = HADDR;
    state_d.rdy = 1'b1;
    state_d.wake = 1'b0;
    state_d.rst = 1'b0;

    // Register writes
    if (wr_lo) begin
      state_d.lo = wctl;
    end
    if (wr_hi) begin
      state_d.hi = wctl;
    end
    if (wsel[3]) begin
      state_d.msk = HWDATA[3:0];
    end
    if (wsel[2]) begin
      ev_clr = HWDATA[3:0];
    end

    // Core level raise must settle before the delay ends
    if (CORE_RAISE) begin
      state_d.raise = 1'b1;
    end
    if (lo_done) begin
      ev_set[`SSMC_EV_LO_DONE] = 1'b1;
      if (state_q.raise) begin
        state_d.raise = 1'b0;
        if (!CORE_SETTLED) begin
          state_d.rst = 1'b1;
          ev_set[`SSMC_EV_RESET] = 1'b1;
          state_d.rst_cnt = state_q.rst_cnt + 8'h01;
        end
      end
    end
    if (hi_done) begin
      ev_set[`SSMC_EV_HI_DONE] = 1'b1;
    end

    // Deep sleep entry and wakeup
    unique case (state_q.mode)
      ssmc_pkg::SSMC_AWAKE: begin
        if (LPM_DEEP) begin
          state_d.mode = ssmc_pkg::SSMC_ENTRY;
          state_d.win = WIN_LD;
          state_d.haz = haz_cfg;
        end
      end
      ssmc_pkg::SSMC_ENTRY: begin
        if (WAKE_IRQ && state_q.haz) begin
          state_d.mode = ssmc_pkg::SSMC_HUNG;
          ev_set[`SSMC_EV_HANG] = 1'b1;
        end else if (WAKE_IRQ) begin
          state_d.mode = ssmc_pkg::SSMC_AWAKE;
          state_d.wake = 1'b1;
          state_d.wake_cnt = state_q.wake_cnt + 8'h01;
        end else if (!LPM_DEEP) begin
          state_d.mode = ssmc_pkg::SSMC_AWAKE;
        end else if (state_q.win == 8'h00) begin
          state_d.mode = ssmc_pkg::SSMC_ASLEEP;
        end else begin
          state_d.win = state_q.win - 8'h01;
        end
      end
      ssmc_pkg::SSMC_ASLEEP: begin
        if (WAKE_IRQ) begin
          state_d.mode = ssmc_pkg::SSMC_AWAKE;
          state_d.wake = 1'b1;
          state_d.wake_cnt = state_q.wake_cnt + 8'h01;
        end else if (!LPM_DEEP) begin
          state_d.mode = ssmc_pkg::SSMC_AWAKE;
        end
      end
      ssmc_pkg::SSMC_HUNG: begin
        // Interrupts and sleep exit are ignored until a clear
        state_d.mode = ssmc_pkg::SSMC_HUNG;
      end
    endcase

    if (POWER_UP_CLEAR) begin
      state_d.mode = ssmc_pkg::SSMC_AWAKE;
      state_d.haz = 1'b0;
      state_d.raise = 1'b0;
      state_d.wake = 1'b0;
    end
    state_d.hang = (state_d.mode == ssmc_pkg::SSMC_HUNG);

    // Supervisor and monitor modes
    deep = (state_d.mode != ssmc_pkg::SSMC_AWAKE);
    for (int i = 0; i < 4; i++) begin
      state_d.st[2*i +: 2] = deep ? slp_m[i] : act_m[i];
    end
    state_d.wfast = fast_w[0];

    // Sticky events, set wins over clear
    state_d.evt = (state_q.evt & ~ev_clr) | ev_set;
    state_d.irq = |(state_d.evt & state_d.msk);

    // Read data, with this cycle's write forwarded
    // One select at most is high, unmapped reads stay zero
    if (rsel[0]) begin
      rd = {26'h0, state_d.lo};
    end else if (rsel[1]) begin
      rd = {26'h0, state_d.hi};
    end else if (rsel[2]) begin
      rd = {22'h0, pend, 4'h0, state_d.evt};
    end else if (rsel[3]) begin
      rd = {28'h0, state_d.msk};
    end else if (rsel[4]) begin
      rd = {20'h0, deep, state_d.hang, haz_cfg, state_d.wfast, state_d.st};
    end else if (rsel[5]) begin
      rd = {16'h0, state_d.rst_cnt, state_d.wake_cnt};
    end else begin
      rd = 32'h0000_0000;
    end
    if (acc && !HWRITE) begin
      state_d.rdata = rd;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign HRDATA = state_q.rdata;
  assign HREADYOUT = state_q.rdy;
  assign HRESP = 1'b0;
  assign LOW_SUP_STATE = state_q.st[1:0];
  assign LOW_MON_STATE = state_q.st[3:2];
  assign HIGH_SUP_STATE = state_q.st[5:4];
  assign HIGH_MON_STATE = state_q.st[7:6];
  assign WAKE_FAST = state_q.wfast;
  assign WAKE_OUT = state_q.wake;
  assign HANG = state_q.hang;
  assign RESET_REQ = state_q.rst;
  assign IRQ = state_q.irq;

endmodule : ssmc_top

`default_nettype wire

// file: dv/ssmc_chk_monitor.sv
// Purpose: Assertions on wake, hang and settle-reset outputs
// Assumes: Bound to ssmc_top, one clock
// Notes: Sees top ports only
`timescale 1ns/1ps
`default_nettype none

module ssmc_chk_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WAKE_IRQ,
  input wire logic CORE_SETTLED,
  input wire logic POWER_UP_CLEAR,
  input wire logic WAKE_OUT,
  input wire logic HANG,
  input wire logic RESET_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  hang_hold_a: assert property (HANG && !POWER_UP_CLEAR |=> HANG)
    else $error("hang dropped without clear");
  hang_clear_a: assert property (HANG && POWER_UP_CLEAR |=> !HANG)
    else $error("hang not cleared");
  hang_cause_a: assert property ($rose(HANG) |-> $past(WAKE_IRQ))
    else $error("hang without interrupt");
  hang_quiet_a: assert property (HANG |-> !WAKE_OUT)
    else $error("wake granted while hung");
  wake_pulse_a: assert property (WAKE_OUT |=> !WAKE_OUT)
    else $error("wake pulse too long");
  wake_cause_a: assert property (WAKE_OUT |-> $past(WAKE_IRQ))
    else $error("wake without interrupt");
  rreq_pulse_a: assert property (RESET_REQ |=> !RESET_REQ)
    else $error("reset request too long");
  rreq_cause_a: assert property (RESET_REQ |-> !$past(CORE_SETTLED))
    else $error("reset request with core settled");

  cover property (RESET_REQ);
  cover property ($rose(HANG));
  cover property (WAKE_OUT);
endmodule : ssmc_chk_monitor

bind ssmc_top ssmc_chk_monitor i_mon (.CLK, .RESET_N, .WAKE_IRQ, .CORE_SETTLED, .POWER_UP_CLEAR, .WAKE_OUT,
  .HANG, .RESET_REQ);

`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench of the supervisor mode control
// Assumes: Settle count shortened to 40 cycles
// Notes: Random control words from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int NORM = 40;
  logic clk = 0, rst_n = 0, hsel = 1, hwrite = 0, hready, hreadyout, hresp;
  logic [1:0] htrans = 0, lo_sup, lo_mon, hi_sup, hi_mon;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic deep = 0, irq_in = 0, raise = 0, settled = 1, power_up_clear = 0, seen;
  logic wfast, wake, hang, rreq, irq;
  logic [5:0] lo, hi;
  logic [5:0] cl [4] = '{6'h11, 6'h15, 6'h15, 6'h00};
  logic [5:0] ch [4] = '{6'h11, 6'h11, 6'h13, 6'h09};
  logic he [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int num_errors = 0, n_compared = 0, seed = 34448, cyc = 0, nw = 0, t0, tf, k;

  assign hready = hreadyout;
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (wake === 1'b1) nw <= nw + 1;

  ssmc_top #(.NORM_DLY_CYC(NORM)) i_dut (.CLK(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .LPM_DEEP(deep), .WAKE_IRQ(irq_in), .CORE_RAISE(raise), .CORE_SETTLED(settled),
    .POWER_UP_CLEAR(power_up_clear), .LOW_SUP_STATE(lo_sup), .LOW_MON_STATE(lo_mon), .HIGH_SUP_STATE(hi_sup),
    .HIGH_MON_STATE(hi_mon), .WAKE_FAST(wfast), .WAKE_OUT(wake), .HANG(hang), .RESET_REQ(rreq), .IRQ(irq));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One single word transfer, entered just after an edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic logic [1:0] md(input logic en, keep, fp, au, dp);
    if (!en) return 2'h0;
    if (!dp || (keep && !au)) return fp ? 2'h2 : 2'h1;
    if (keep && fp) return 2'h1;
    return 2'h0;
  endfunction : md

  task automatic core_up(input logic s, input logic r_exp, input logic i_exp);
    settled <= s;
    raise <= 1;
    @(posedge clk);
    raise <= 0;
    t0 = cyc;
    seen = 0;
    tf = 0;
    repeat (420) begin
      @(posedge clk);
      if (rreq === 1'b1 && !seen) tf = cyc - t0;
      seen |= rreq;
    end
    chk("reset_req", r_exp, seen);
    if (r_exp) chk("reset_time", 1, tf >= 398 && tf <= 404);
    chk("irq", i_exp, irq);
    ahb(1, 32'h8, 32'hf);
  endtask : core_up

  task automatic sleep_irq(input logic h);
    k = nw;
    deep <= 1;
    tick(3);
    irq_in <= 1;
    @(posedge clk);
    irq_in <= 0;
    tick(2);
    chk("hang", h, hang);
    chk("wakes", !h, nw - k);
    deep <= 0;
    power_up_clear <= 1;
    @(posedge clk);
    power_up_clear <= 0;
    tick(2);
    chk("hang_clr", 0, hang);
  endtask : sleep_irq

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    tick(2);
    chk("modes", 8'h55, {lo_sup, lo_mon, hi_sup, hi_mon});
    ahb(1, 32'h18, 32'hffff);
    foreach (cl[i]) begin
      ahb(0, 32'h4 * i + (i == 3 ? 32'h0c : 32'h0), 0);
      chk("reg_reset", i < 2 ? 32'h11 : 32'h0, rd);
    end
    for (int i = 0; i < 12; i++) begin
      lo = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      hi = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
      ahb(1, 32'h0, {26'h0, lo});
      ahb(1, 32'h4, {26'h0, hi});
      for (int d = 0; d < 2; d++) begin
        deep <= d[0];
        tick(4);
        chk("lo_sup", md(lo[0], lo[1], lo[2], lo[3], d[0]), lo_sup);
        chk("lo_mon", md(lo[4], 1'b1, lo[5], lo[3], d[0]), lo_mon);
        chk("hi_sup", md(hi[0], hi[1], hi[2], hi[3], d[0]), hi_sup);
        chk("hi_mon", md(hi[4], 1'b1, hi[5], hi[3], d[0]), hi_mon);
      end
      chk("wfast", !lo[0] || lo[2], wfast);
      deep <= 0;
      tick(4);
    end
    tick(450);
    for (int j = 0; j < 2; j++) begin
      ahb(1, 32'h0, j ? 32'h15 : 32'h11);
      t0 = cyc;
      ahb(0, 32'h8, 0);
      chk("pend_lo", 1, rd[8]);
      while (rd[8] === 1'b1) ahb(0, 32'h8, 0);
      chk("settle", 1, cyc - t0 >= (j ? 400 : NORM) && cyc - t0 <= (j ? 400 : NORM) + 6);
      chk("done_evt", 1, rd[0]);
      ahb(1, 32'h8, 32'hf);
      ahb(0, 32'h8, 0);
      chk("evt_w1c", 0, rd[0]);
    end
    ahb(1, 32'hc, 32'h4);
    core_up(0, 1, 1);
    ahb(1, 32'hc, 32'h0);
    core_up(0, 1, 0);
    ahb(1, 32'h0, 32'h11);
    core_up(1, 0, 0);
    foreach (cl[i]) begin
      ahb(1, 32'h0, {26'h0, cl[i]});
      ahb(1, 32'h4, {26'h0, ch[i]});
      tick(450);
      sleep_irq(he[i]);
    end
    ahb(1, 32'h4, 32'h13);
    sleep_irq(1);
    ahb(0, 32'h14, 0);
    chk("counters", 32'h0000_0202, rd);
    chk("hresp", 0, hresp);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
